/* core/ris_qual_cnt.sv */
/*
  Saturating qualification counter: counts ticks while a request level holds
  and flags once the count reaches a limit.
  Assumes tick and req are already synchronous to clk.
*/
`timescale 1ns/10ps
module ris_qual_cnt #(
  parameter int unsigned W     = 6,
  parameter int unsigned LIMIT = 32
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Request and tick
  input  wire logic         req,
  input  wire logic         tick,
  // Result
  output logic              done
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         done_r;
  wire          at_limit = (cnt_r >= W'(LIMIT));

  // Restart on any drop of the request, saturate at the limit
  assign cnt_nxt = !req ? '0 : (tick && !at_limit) ? cnt_r + 1'b1 : cnt_r;

  // Count register
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_r <= '0;
    else if (ce)
      cnt_r <= cnt_nxt;
  end

  // Done flag
  always_ff @(posedge clk)
  begin
    if (rst)
      done_r <= 1'b0;
    else if (ce)
      done_r <= req && (cnt_nxt >= W'(LIMIT));
  end

  assign done = done_r;

endmodule

/* core/ris_reset_seq.sv */
/*
  Reset initialization sequencer: acts on power-on at once, qualifies hard and soft reset,
  stretches its own open-drain reset outputs, samples strap pins at power-on
  release and releases and re-takes them around hard reset.
  Assumes board pins are asynchronous to ref_clk and that the primary and bus
  clock inputs are slow enough to be sampled as levels by ref_clk.
*/
`timescale 1ns/10ps
module ris_reset_seq (
  // Clock, reset and enable
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  // Mode and clock sources
  input  wire logic                 host_mode,
  input  wire logic                 primary_clock_in,
  input  wire logic                 bus_clock_in,
  // Power-on reset, active low
  input  wire logic                 power_on_reset_in_n,
  // Open-drain reset lines, active low
  input  wire logic                 hard_reset_line_n_in,
  input  wire logic                 soft_reset_line_n_in,
  output ris_pkg::ris_rst_drv_t     rst_drv,
  // Strap pins, shared with device outputs
  input  wire ris_pkg::ris_cfg_t    cfg_in,
  output ris_pkg::ris_cfg_t         cfg_out,
  output logic                      cfg_oe,
  // Sampled strap values and status
  output ris_pkg::ris_cfg_t         cfg_latched,
  output logic                      core_reset,
  output logic                      sync_tick
);

  // Two-flop synchronisers for every pin input except the mode strap
  logic [5+ris_pkg::CFG_W-1:0] s1_r;
  logic [5+ris_pkg::CFG_W-1:0] s2_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s1_r <= ris_pkg::PIN_SYNC_RST; // Power-on held until the pin is really seen
      s2_r <= ris_pkg::PIN_SYNC_RST;
    end
    else if (clk_en)
    begin
      s1_r <= {primary_clock_in, bus_clock_in, power_on_reset_in_n, hard_reset_line_n_in,
               soft_reset_line_n_in, cfg_in};
      s2_r <= s1_r;
    end
  end

  // Mode strap synchroniser, left unreset so it has settled when reset ends
  logic [1:0] mode_sync_r;

  always_ff @(posedge ref_clk)
  begin
    if (clk_en)
      mode_sync_r <= {mode_sync_r[0], host_mode};
  end

  wire               host_s  = mode_sync_r[1];
  wire               pclk_s  = s2_r[8];
  wire               bclk_s  = s2_r[7];
  wire               por_a   = !s2_r[6];
  wire               hard_a  = !s2_r[5];
  wire               soft_a  = !s2_r[4];
  ris_pkg::ris_cfg_t cfg_s;
  assign cfg_s = s2_r[3:0];

  // Rising-edge detection of the chosen primary clock
  logic src_d_r;
  wire  src_s   = host_s ? pclk_s : bclk_s;
  wire  src_rise = src_s && !src_d_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      src_d_r <= 1'b0;
    else if (clk_en)
      src_d_r <= src_s;
  end

  // Sync-clock tick: in host mode divided per sampled strap
  logic [ris_pkg::DIV_W-1:0] div_cnt_r;
  logic                      tick_r;
  wire  [ris_pkg::DIV_W-1:0] div_lim = (host_s && cfg_latched.clk_div) ? ris_pkg::DIV_TWO
                                                                           : ris_pkg::DIV_ONE;
  wire                       div_wrap = src_rise && (div_cnt_r >= div_lim);
  wire                       tick = host_s ? div_wrap : src_rise;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
    end
    else if (clk_en)
    begin
      div_cnt_r <= div_wrap ? '0 : src_rise ? div_cnt_r + 1'b1 : div_cnt_r;
      tick_r    <= tick;
    end
  end
  assign sync_tick = tick_r;

  // Power-on setup window: last straps seen 4 clocks before release count
  localparam int unsigned SW = ris_pkg::SETUP_PERIODS;
  ris_pkg::ris_cfg_t cfg_hist_r [SW];
  ris_pkg::ris_cfg_t cfg_lat_r;
  logic              por_d_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < SW; i++)
        cfg_hist_r[i] <= ris_pkg::CFG_RST_VAL;
      cfg_lat_r <= ris_pkg::CFG_RST_VAL;
      por_d_r   <= 1'b1;
    end
    else if (clk_en)
    begin
      por_d_r <= por_a;
      if (src_rise)
      begin
        cfg_hist_r[0] <= cfg_s;
        for (int i = 1; i < SW; i++)
          cfg_hist_r[i] <= cfg_hist_r[i-1];
      end
      if (por_d_r && !por_a)
        cfg_lat_r <= cfg_hist_r[SW-1];
    end
  end
  assign cfg_latched = cfg_lat_r;

  // Sequencer state and counter
  ris_pkg::ris_state_t          st_r;
  ris_pkg::ris_state_t          st_nxt;
  logic [ris_pkg::CNT_W-1:0]    cnt_r;
  logic [ris_pkg::CNT_W-1:0]    cnt_nxt;
  logic                         drv_hard;
  logic                         drv_soft;

  // Qualification of hard and soft reset requests; our own low drive is no request
  logic hs_qual;
  wire  qual_req = (hard_a || soft_a) && !drv_soft;
  ris_qual_cnt #(
    .W     (6),
    .LIMIT (ris_pkg::QUAL_PERIODS)
  ) u_qual (
    .clk   (ref_clk),
    .rst   (sys_rst),
    .ce    (clk_en),
    .req   (qual_req),
    .tick  (tick),
    .done  (hs_qual)
  );

  assign drv_hard = (st_r == ris_pkg::RIS_STRETCH);
  assign drv_soft = (st_r == ris_pkg::RIS_STRETCH) || (st_r == ris_pkg::RIS_SOFTLAG);

  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    if (por_a)
    begin
      st_nxt  = ris_pkg::RIS_POR;
      cnt_nxt = '0;
    end
    else
      case (st_r)
        ris_pkg::RIS_POR:
        begin
          st_nxt  = ris_pkg::RIS_STRETCH;
          cnt_nxt = '0;
        end
        ris_pkg::RIS_RUN:
          if (hs_qual)
          begin
            st_nxt  = ris_pkg::RIS_STRETCH;
            cnt_nxt = '0;
          end
        ris_pkg::RIS_STRETCH:
          if (tick)
          begin
            cnt_nxt = cnt_r + 1'b1;
            // One extra tick: the first may end only a partial period
            if (cnt_r == ris_pkg::CNT_W'(ris_pkg::STRETCH_PERIODS))
            begin
              st_nxt  = ris_pkg::RIS_SOFTLAG;
              cnt_nxt = '0;
            end
          end
        ris_pkg::RIS_SOFTLAG:
          if (tick)
          begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == ris_pkg::CNT_W'(ris_pkg::SOFT_LAG_PERIODS - 1))
            begin
              st_nxt  = ris_pkg::RIS_WAITREL;
              cnt_nxt = '0;
            end
          end
        ris_pkg::RIS_WAITREL:
          if (!hard_a && !soft_a)
            st_nxt = ris_pkg::RIS_REDRIVE;
        ris_pkg::RIS_REDRIVE:
          if (tick)
            st_nxt = ris_pkg::RIS_RUN;
        default:
          st_nxt = ris_pkg::RIS_POR;
      endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_r  <= ris_pkg::RIS_POR;
      cnt_r <= '0;
    end
    else if (clk_en)
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Ticks since hard reset was last low; two edges guarantee one full period
  wire        hard_any = drv_hard || hard_a;
  logic [1:0] redrive_r;
  wire        redrive_ok = (redrive_r > 2'(ris_pkg::REDRIVE_PERIODS));

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      redrive_r <= 2'h0;
    else if (clk_en)
      redrive_r <= hard_any ? 2'h0 : (tick && !redrive_ok) ? redrive_r + 2'h1 : redrive_r;
  end

  // Outputs: open-drain low drive, strap pin drive, core reset
  wire cfg_oe_nxt = (st_nxt == ris_pkg::RIS_RUN) && !hard_any && redrive_ok;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rst_drv    <= '0;
      cfg_out    <= ris_pkg::CFG_RST_VAL;
      cfg_oe     <= 1'b0;
      core_reset <= 1'b1;
    end
    else if (clk_en)
    begin
      rst_drv.hard_low_oe <= (st_nxt == ris_pkg::RIS_STRETCH);
      rst_drv.soft_low_oe <= (st_nxt == ris_pkg::RIS_STRETCH) || (st_nxt == ris_pkg::RIS_SOFTLAG);
      cfg_out    <= cfg_lat_r;
      cfg_oe     <= cfg_oe_nxt;
      core_reset <= (st_nxt != ris_pkg::RIS_RUN);
    end
  end

endmodule

/* include/ris_pkg.sv */
/*
  Package for the reset initialization sequencer: timing counts, strap layout,
  state codes and the carriers that group related signals.
  Assumes a single 25 MHz ref_clk domain; no other package is needed.
*/
package ris_pkg;

  // Clock rate of ref_clk
  localparam int unsigned REF_CLK_HZ       = 25_000_000;
  localparam int unsigned REF_PERIOD_PS    = 40_000;

  // Reset qualification and stretch figures, in sync-clock periods; setup in primary clock periods
  localparam int unsigned QUAL_PERIODS     = 32;
  localparam int unsigned POR_PERIODS      = 32;
  localparam int unsigned STRETCH_PERIODS  = 512;
  localparam int unsigned SOFT_LAG_PERIODS = 16;
  localparam int unsigned SETUP_PERIODS    = 4;
  localparam int unsigned REDRIVE_PERIODS  = 1;

  // Release of strap pins after hard reset assertion, longest time
  localparam int unsigned CFG_OFF_NS       = 4;
  localparam int unsigned CFG_OFF_CYC_RAW  = (CFG_OFF_NS * 1000) / REF_PERIOD_PS;
  localparam int unsigned CFG_OFF_CYC      = (CFG_OFF_CYC_RAW < 1) ? 1 : CFG_OFF_CYC_RAW;

  // Strap layout: boot source in [3:1], clock divide in [0]
  localparam int unsigned BOOT_SRC_W       = 3;
  localparam int unsigned CFG_W            = 4;
  localparam int unsigned CFG_DIV_BIT      = 0;
  localparam int unsigned CFG_BOOT_LSB     = 1;
  localparam logic [3:0]  CFG_RST_VAL      = 4'h0;

  // Pin synchroniser reset: clocks low, power-on reset asserted, lines released
  localparam logic [8:0]  PIN_SYNC_RST     = 9'h030;

  // Sync-clock divider: divide by 2 or by 1 of the primary clock tick
  localparam int unsigned DIV_W            = 2;
  localparam logic [1:0]  DIV_ONE          = 2'h0;
  localparam logic [1:0]  DIV_TWO          = 2'h1;

  // Counter width for the longest count
  localparam int unsigned CNT_W            = 10;

  // Sequencer states
  typedef enum logic [5:0] {
    RIS_POR     = 6'h01,
    RIS_RUN     = 6'h02,
    RIS_STRETCH = 6'h04,
    RIS_SOFTLAG = 6'h08,
    RIS_REDRIVE = 6'h10,
    RIS_WAITREL = 6'h20
  } ris_state_t;

  // Open-drain pin carrier: drive-low enables for the hard and soft lines
  typedef struct packed {
    logic hard_low_oe;
    logic soft_low_oe;
  } ris_rst_drv_t;

  // Strap pin carrier
  typedef struct packed {
    logic [2:0] boot_src;
    logic       clk_div;
  } ris_cfg_t;

endpackage

/* verif/ris_board_model.sv */
/* Board model: pulled-up reset lines and strap resistors.
   Assumes the bench drives the board-side requests. */
`timescale 1ns/10ps
module ris_board_model (
  // Device side
  input  wire ris_pkg::ris_rst_drv_t rst_drv,
  input  wire ris_pkg::ris_cfg_t     cfg_out,
  input  wire logic                  cfg_oe,
  // Board requests
  input  wire logic                  ext_hard_n,
  input  wire ris_pkg::ris_cfg_t     strap,
  // Resolved pins
  output logic                       hard_n,
  output logic                       soft_n,
  output ris_pkg::ris_cfg_t          cfg_pin
);
  // Lines low while any party pulls, else pulled up
  assign hard_n  = ext_hard_n & ~rst_drv.hard_low_oe;
  assign soft_n  = ~rst_drv.soft_low_oe;
  // Straps show whenever the device lets go
  assign cfg_pin = cfg_oe ? cfg_out : strap;
endmodule

/* verif/ris_reset_seq_chk.sv */
/* Port checker for the reset sequencer.
   Assumes one ref_clk domain; bound onto ris_reset_seq below. */
`timescale 1ns/10ps
module ris_reset_seq_chk (
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  // Watched ports
  input wire logic                  host_mode,
  input wire logic                  primary_clock_in,
  input wire logic                  bus_clock_in,
  input wire logic                  hard_reset_line_n_in,
  input wire ris_pkg::ris_rst_drv_t rst_drv,
  input wire ris_pkg::ris_cfg_t     cfg_latched,
  input wire logic                  cfg_oe,
  input wire logic                  core_reset,
  input wire logic                  sync_tick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [9:0] q_r;
  logic [9:0] h_r;
  logic [9:0] s_r;
  // Ticks seen: line low, hard driven, soft driven alone
  always_ff @(posedge ref_clk)
  begin
    q_r <= (sys_rst | hard_reset_line_n_in) ? 10'h000 : q_r + 10'(sync_tick);
    h_r <= (sys_rst | ~rst_drv.hard_low_oe) ? 10'h000 : h_r + 10'(sync_tick);
    s_r <= (sys_rst | rst_drv.hard_low_oe | ~rst_drv.soft_low_oe) ? 10'h000 : s_r + 10'(sync_tick);
  end
  sequence s_ext_low;
    !hard_reset_line_n_in [*4];
  endsequence
  property p_qual;
    $rose(rst_drv.hard_low_oe) && !$past(core_reset) |-> q_r >= 10'h01F;
  endproperty
  property p_stretch;
    $fell(rst_drv.hard_low_oe) |-> h_r >= 10'h1FF;
  endproperty
  property p_lag;
    $fell(rst_drv.soft_low_oe) |-> s_r >= 10'h00F;
  endproperty
  property p_off;
    s_ext_low |-> !cfg_oe;
  endproperty
  property p_on;
    $rose(cfg_oe) |-> hard_reset_line_n_in && $past(hard_reset_line_n_in, 3);
  endproperty
  property p_agent;
    !host_mode && $rose(bus_clock_in) |-> ##[1:6] sync_tick;
  endproperty
  // Only while running: the divide strap is re-latched at power-on release
  property p_host;
    host_mode && !core_reset && !cfg_latched.clk_div && $rose(primary_clock_in) |-> ##[1:6] sync_tick;
  endproperty
  property p_od;
    rst_drv.hard_low_oe |-> rst_drv.soft_low_oe && core_reset && !cfg_oe;
  endproperty
  a_qual: assert property (p_qual)
    else $error("hard drive without qualified request");
  a_stretch: assert property (p_stretch)
    else $error("hard drive too short");
  a_lag: assert property (p_lag)
    else $error("soft release too early");
  a_off: assert property (p_off)
    else $error("straps still driven in hard reset");
  a_on: assert property (p_on)
    else $error("straps driven too soon");
  a_agent: assert property (p_agent)
    else $error("bus clock edge gave no tick");
  a_host: assert property (p_host)
    else $error("primary clock edge gave no tick");
  a_od: assert property (p_od)
    else $error("bad drive combination");
endmodule

bind ris_reset_seq ris_reset_seq_chk chk_u (.ref_clk, .sys_rst, .host_mode, .primary_clock_in, .bus_clock_in,
  .hard_reset_line_n_in, .rst_drv, .cfg_latched, .cfg_oe, .core_reset, .sync_tick);

/* verif/tb_ris_reset_seq.sv */
/* Self-checking bench for the reset sequencer.
   Assumes the board model and the bound checker. */
`timescale 1ns/10ps
module tb_ris_reset_seq;
  logic ref_clk = 0, sys_rst = 1, host_mode = 0, pclk = 0, bclk = 0, por_n = 0, ext_hard_n = 1;
  logic hard_n, soft_n, cfg_oe, core_reset, sync_tick;
  ris_pkg::ris_cfg_t strap = '0, cfg_in, cfg_out, cfg_latched, held;
  ris_pkg::ris_rst_drv_t rst_drv;
  int bad_count = 0, n_checks = 0, cyc = 0, ticks = 0, hdrv = 0, sdrv = 0, n;

  ris_reset_seq dut_u (.ref_clk, .sys_rst, .clk_en(1'b1), .host_mode, .primary_clock_in(pclk),
    .bus_clock_in(bclk), .power_on_reset_in_n(por_n), .hard_reset_line_n_in(hard_n),
    .soft_reset_line_n_in(soft_n), .rst_drv, .cfg_in, .cfg_out, .cfg_oe, .cfg_latched,
    .core_reset, .sync_tick);
  ris_board_model brd_u (.rst_drv, .cfg_out, .cfg_oe, .ext_hard_n, .strap, .hard_n, .soft_n,
    .cfg_pin(cfg_in));

  initial forever #20 ref_clk = ~ref_clk;

  // Oscillators (bus 4 cycles, primary 6), tick tallies, run limit
  always @(negedge ref_clk)
  begin
    cyc++;
    if (cyc % 2 == 0) bclk <= ~bclk;
    if (cyc % 3 == 0) pclk <= ~pclk;
    ticks += (sync_tick === 1'b1);
    hdrv += ((sync_tick & rst_drv.hard_low_oe) === 1'b1);
    sdrv += ((sync_tick & rst_drv.soft_low_oe & ~rst_drv.hard_low_oe) === 1'b1);
    if (cyc > 60000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("ERROR t=%0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic chk_v(input string what, input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic run_wait();
    for (int i = 0; i < 20000 && core_reset !== 1'b0; i++) @(negedge ref_clk);
    repeat (40) @(negedge ref_clk);
    chk_v("running", {core_reset, cfg_oe}, 4'h1);
  endtask

  // Power-up with straps held long before and after release
  task automatic power_up(input logic host, input logic div);
    @(negedge ref_clk);
    sys_rst = 1;
    por_n = 0;
    host_mode = host;
    strap = {3'($urandom), div};
    repeat (6) @(negedge ref_clk);
    sys_rst = 0;
    repeat (720) @(negedge ref_clk);
    hdrv = 0;
    sdrv = 0;
    por_n = 1;
    run_wait();
    chk("hard ticks", hdrv, 512, 516);
    chk("soft ticks", sdrv, 16, 20);
    chk_v("latched", cfg_latched, strap);
  endtask

  task automatic rate(input int lo, input int hi);
    ticks = 0;
    repeat (1800) @(negedge ref_clk);
    chk("tick rate", ticks, lo, hi);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    void'($urandom(15993));
    power_up(1'b0, 1'b0);
    rate(449, 451);
    $display("agent power-up done");
    held = cfg_latched;
    n = 4 * ($urandom % 28) + 8;
    ext_hard_n = 0;
    repeat (n) @(negedge ref_clk);
    chk_v("straps off", cfg_oe, 4'h0);
    ext_hard_n = 1;
    repeat (4) @(negedge ref_clk);
    chk_v("straps wait", cfg_oe, 4'h0);
    repeat (96) @(negedge ref_clk);
    chk_v("short ignored", {core_reset, rst_drv}, 4'h0);
    chk_v("straps back", cfg_oe, 4'h1);
    $display("short request done");
    hdrv = 0;
    ext_hard_n = 0;
    repeat (160) @(negedge ref_clk);
    chk_v("flow started", {core_reset, cfg_oe}, 4'h2);
    ext_hard_n = 1;
    run_wait();
    chk("hard ticks", hdrv, 512, 560);
    chk_v("latched kept", cfg_latched, held);
    $display("hard request done");
    power_up(1'b1, 1'b0);
    rate(299, 301);
    power_up(1'b1, 1'b1);
    rate(149, 151);
    $display("host power-up done");
    report_and_stop();
  end
endmodule
